// [core/fan_tach_consts.vh]
// Behaviour
// RL1: Measure fan period by gated 8-bit count
// RL2: Monitor only when start=1, release=0
// RL3: Count from rising edge to next-but-one
// RL4: Store counts in readable speed registers
// RL5: Prescaler 1/2/4/8, default divide-by-two
// RL6: Period counter saturates at all ones
// RL7: Divisors in upper nibble, two bits each
// RL8: Single limit; status when count exceeds
// RL9: Fan sequence starts with analog, then independent
// RL10: Software waits three periods per fan
// RL11: Tamper pin active-high input, open-drain out
// RL12: Tamper status holds while latch high
// RL13: Clear bits pulse pin low, self-clear
// RL14: External latch resets on low level
// RL15: After store, compare, write status bit
// RL16: Mask bit one blocks status contribution
// RL17: OR unmasked status onto active-low alert
// RL18: Alert driven only if enabled, not released
// RL19: Status read returns contents then clears
// RL20: Release bit stops loop, deasserts alert
// RL21: Synchronise tach inputs, detect rising edges
`ifndef FAN_TACH_CONSTS_VH
`define FAN_TACH_CONSTS_VH
`define ADDR_CONFIG        8'h40
`define ADDR_STATUS        8'h41
`define ADDR_MASK          8'h43
`define ADDR_DIVISOR       8'h47
`define ADDR_TAMPER_CLR    8'h46
`define ADDR_FIRST_TACH_INPUT_VALUE    8'h28
`define ADDR_SECOND_TACH_INPUT_VALUE    8'h29
`define ADDR_FIRST_TACH_INPUT_LIMIT    8'h3B
`define ADDR_SECOND_TACH_INPUT_LIMIT    8'h3C
`define CFG_START_BIT      0
`define CFG_ALERT_EN_BIT   1
`define CFG_RELEASE_BIT    3
`define CFG_TAMPER_CLR_BIT 6
`define TCLR_BIT           7
`define ST_FIRST_TACH_INPUT_BIT        0
`define ST_SECOND_TACH_INPUT_BIT        1
`define ST_TAMPER_BIT      2
`define CFG_RESET          8'h08
`define DIVISOR_RESET      8'h50
`define MASK_RESET         8'h00
`define OSC_HZ             22500
`define CLK_HZ             250000000
`define TAMPER_PULSE_MS    20
`define TAMPER_PULSE_CYC   ((`CLK_HZ / 1000) * `TAMPER_PULSE_MS)
`define OSC_DIV_CYC        (`CLK_HZ / `OSC_HZ)
`endif

// [core/fan_period_counter.v]
`timescale 1ns/1ps
`default_nettype none
`include "fan_tach_consts.vh"
module fan_period_counter #(
   parameter WIDTH = 8
) (
   input  wire             core_clk_in,
   input  wire             rst_in,
   input  wire             run_in,
   input  wire             tach_in,
   input  wire             osc_tick_in,
   input  wire [1:0]       divisor_in,
   output reg  [WIDTH-1:0] count_out,
   output reg              done_out
);
   reg             sync1_r;
   reg             sync2_r;
   reg             prev_r;
   reg [1:0]       edges_r;
   reg [2:0]       pre_r;
   reg [WIDTH-1:0] cnt_r;
   wire            rise;
   wire            pre_tick;

   assign rise = sync2_r & ~prev_r; // RL21
   // Prescaler passes every 2^divisor-th oscillator tick
   assign pre_tick = osc_tick_in & ((pre_r & ((3'h1 << divisor_in) - 3'h1)) == 3'h0); // RL5

   always @(posedge core_clk_in) begin
      sync1_r <= tach_in; // RL21
      sync2_r <= sync1_r;
      prev_r  <= sync2_r;
      done_out <= 1'b0;
      if (rst_in) begin
         edges_r   <= 2'h0;
         pre_r     <= 3'h0;
         cnt_r     <= {WIDTH{1'b0}};
         count_out <= {WIDTH{1'b0}};
      end else if (!run_in) begin
         edges_r <= 2'h0; // RL2
         pre_r   <= 3'h0;
      end else begin
         if (osc_tick_in)
            pre_r <= pre_r + 3'h1;
         if (rise) begin
            if (edges_r == 2'h0) begin
               edges_r <= 2'h1; // RL3
               cnt_r   <= {WIDTH{1'b0}};
               pre_r   <= 3'h0;
            end else if (edges_r == 2'h1) begin
               edges_r <= 2'h2;
            end else begin
               edges_r   <= 2'h0; // RL3
               count_out <= cnt_r; // RL4
               done_out  <= 1'b1;
            end
         end else if (edges_r != 2'h0 && pre_tick && cnt_r != {WIDTH{1'b1}}) begin
            cnt_r <= cnt_r + 1'b1; // RL1 RL6
         end
      end
   end
endmodule
`default_nettype wire

// [core/fan_tach_tamper_alert_logic.v]
`timescale 1ns/1ps
`default_nettype none
`include "fan_tach_consts.vh"
module fan_tach_tamper_alert_logic #(
   parameter TAMPER_PULSE_CYC = `TAMPER_PULSE_CYC,
   parameter OSC_DIV_CYC      = `OSC_DIV_CYC
) (
   input  wire       core_clk_in,
   input  wire       rst_in,
   input  wire [7:0] addr_in,
   input  wire [7:0] wdata_in,
   input  wire       wr_in,
   input  wire       rd_in,
   output reg  [7:0] rdata_out,
   input  wire       first_tach_input_in,
   input  wire       second_tach_input_in,
   input  wire       tamper_pin_in,
   output wire       tamper_pin_out,
   output wire       tamper_pin_oe_out,
   output wire       alert_n_out,
   output wire       alert_n_oe_out
);
   reg  [7:0]  cfg_r;
   reg  [7:0]  div_r;
   reg  [7:0]  mask_r;
   reg  [7:0]  status_r;
   reg  [7:0]  status_nxt;
   reg  [7:0]  lim1_r;
   reg  [7:0]  lim2_r;
   reg         tclr_r;
   reg  [31:0] osc_cnt_r;
   reg         osc_tick_r;
   reg  [31:0] pulse_cnt_r;
   reg         pulse_state_r;
   reg         t_sync1_r;
   reg         t_sync2_r;
   reg  [7:0]  rd_sel;
   reg         first_tach_input_hit;
   reg         second_tach_input_hit;
   reg         tamper_set;
   wire        run;
   wire [7:0]  cnt1;
   wire [7:0]  cnt2;
   wire        done1;
   wire        done2;
   wire        pulse_busy;
   wire        clr_req;
   wire        rd_status;
   wire        wr_cfg;
   wire        wr_div;
   wire        wr_mask;
   wire        wr_lim1;
   wire        wr_lim2;
   wire        wr_tclr;
   wire [7:0]  unmasked;
   wire        alert_allowed;

   localparam PULSE_IDLE = 1'b0;
   localparam PULSE_LOW  = 1'b1;

   // Address compare shared by the write, read and clear paths
   function addr_is;
      input [7:0] addr;
      input [7:0] target;
      begin
         addr_is = (addr == target);
      end
   endfunction

   // Period grows as speed falls, so a slow fan shows a count above its limit
   function over_limit;
      input [7:0] count;
      input [7:0] limit;
      begin
         over_limit = (count > limit);
      end
   endfunction

   // A fresh hardware result beats a read-clear in the same cycle
   function status_bit;
      input update;
      input value;
      input rd_clear;
      input current;
      begin
         if (update)
            status_bit = value;
         else if (rd_clear)
            status_bit = 1'b0;
         else
            status_bit = current;
      end
   endfunction

   // Fan and analog sequences share only this start condition
   assign run = cfg_r[`CFG_START_BIT] & ~cfg_r[`CFG_RELEASE_BIT]; // RL2 RL9 RL20

   // Oscillator tick made from the core clock, so no second clock domain exists
   always @(posedge core_clk_in) begin
      if (rst_in) begin
         osc_cnt_r  <= 32'h0000_0000;
         osc_tick_r <= 1'b0;
      end else if (osc_cnt_r == OSC_DIV_CYC - 1) begin
         osc_cnt_r  <= 32'h0000_0000;
         osc_tick_r <= 1'b1;
      end else begin
         osc_cnt_r  <= osc_cnt_r + 32'h0000_0001;
         osc_tick_r <= 1'b0;
      end
   end

   fan_period_counter #(.WIDTH(8)) u_first_tach_input (
      .core_clk_in (core_clk_in),
      .rst_in      (rst_in),
      .run_in      (run),
      .tach_in     (first_tach_input_in),
      .osc_tick_in (osc_tick_r),
      .divisor_in  (div_r[5:4]), // RL7
      .count_out   (cnt1),
      .done_out    (done1)
   );

   fan_period_counter #(.WIDTH(8)) u_second_tach_input (
      .core_clk_in (core_clk_in),
      .rst_in      (rst_in),
      .run_in      (run),
      .tach_in     (second_tach_input_in),
      .osc_tick_in (osc_tick_r),
      .divisor_in  (div_r[7:6]), // RL7
      .count_out   (cnt2),
      .done_out    (done2)
   );

   always @(posedge core_clk_in) begin
      if (rst_in) begin
         t_sync1_r <= 1'b0;
         t_sync2_r <= 1'b0;
      end else begin
         t_sync1_r <= tamper_pin_in; // RL11
         t_sync2_r <= t_sync1_r;
      end
   end

   assign wr_cfg  = wr_in && addr_is(addr_in, `ADDR_CONFIG);
   assign wr_div  = wr_in && addr_is(addr_in, `ADDR_DIVISOR);
   assign wr_mask = wr_in && addr_is(addr_in, `ADDR_MASK);
   assign wr_lim1 = wr_in && addr_is(addr_in, `ADDR_FIRST_TACH_INPUT_LIMIT);
   assign wr_lim2 = wr_in && addr_is(addr_in, `ADDR_SECOND_TACH_INPUT_LIMIT);
   assign wr_tclr = wr_in && addr_is(addr_in, `ADDR_TAMPER_CLR);

   assign clr_req = (wr_cfg && wdata_in[`CFG_TAMPER_CLR_BIT]) ||
                    (wr_tclr && wdata_in[`TCLR_BIT]);
   assign pulse_busy = (pulse_state_r == PULSE_LOW);

   // A clear during a pulse restarts it, so the low time never falls short
   always @(posedge core_clk_in) begin
      if (rst_in) begin
         pulse_state_r <= PULSE_IDLE;
         pulse_cnt_r   <= 32'h0000_0000;
      end else begin
         case (pulse_state_r)
            PULSE_IDLE: begin
               if (clr_req) begin
                  pulse_state_r <= PULSE_LOW;
                  pulse_cnt_r   <= TAMPER_PULSE_CYC; // RL13
               end
            end
            PULSE_LOW: begin
               if (clr_req) begin
                  pulse_cnt_r <= TAMPER_PULSE_CYC; // RL13
               end else if (pulse_cnt_r <= 32'h0000_0001) begin
                  pulse_state_r <= PULSE_IDLE;
                  pulse_cnt_r   <= 32'h0000_0000;
               end else begin
                  pulse_cnt_r <= pulse_cnt_r - 32'h0000_0001;
               end
            end
            default: begin
               pulse_state_r <= PULSE_IDLE;
               pulse_cnt_r   <= 32'h0000_0000;
            end
         endcase
      end
   end

   assign tamper_pin_out    = 1'b0;
   assign tamper_pin_oe_out = pulse_busy; // RL13 RL14

   assign rd_status = rd_in && addr_is(addr_in, `ADDR_STATUS);

   // Tamper status is held off while our own pulse pulls the pin low
   always @* begin
      first_tach_input_hit   = over_limit(cnt1, lim1_r); // RL8
      second_tach_input_hit   = over_limit(cnt2, lim2_r); // RL8
      tamper_set = t_sync2_r & ~pulse_busy; // RL11 RL12
      status_nxt = 8'h00;
      status_nxt[`ST_FIRST_TACH_INPUT_BIT] = status_bit(done1, first_tach_input_hit, rd_status,
                                            status_r[`ST_FIRST_TACH_INPUT_BIT]); // RL15 RL19
      status_nxt[`ST_SECOND_TACH_INPUT_BIT] = status_bit(done2, second_tach_input_hit, rd_status,
                                            status_r[`ST_SECOND_TACH_INPUT_BIT]); // RL15 RL19
      status_nxt[`ST_TAMPER_BIT] = status_bit(tamper_set, 1'b1, rd_status,
                                              status_r[`ST_TAMPER_BIT]); // RL12
   end

   always @(posedge core_clk_in) begin
      if (rst_in)
         status_r <= 8'h00;
      else
         status_r <= status_nxt;
   end

   // Release starts set, so monitoring and the alert stay off until started
   always @(posedge core_clk_in) begin
      if (rst_in) begin
         cfg_r <= `CFG_RESET;
      end else if (wr_cfg) begin
         cfg_r <= wdata_in & 8'h4B;
      end else begin
         cfg_r[`CFG_TAMPER_CLR_BIT] <= 1'b0; // RL13
      end
   end

   // Lower nibble is not ours; only the divisor fields are kept
   always @(posedge core_clk_in) begin
      if (rst_in) begin
         div_r <= `DIVISOR_RESET; // RL5
      end else if (wr_div) begin
         div_r <= {wdata_in[7:4], 4'h0}; // RL7
      end
   end

   always @(posedge core_clk_in) begin
      if (rst_in) begin
         mask_r <= `MASK_RESET;
      end else if (wr_mask) begin
         mask_r <= wdata_in & 8'h07; // RL16
      end
   end

   always @(posedge core_clk_in) begin
      if (rst_in) begin
         lim1_r <= 8'hFF;
      end else if (wr_lim1) begin
         lim1_r <= wdata_in;
      end
   end

   always @(posedge core_clk_in) begin
      if (rst_in) begin
         lim2_r <= 8'hFF;
      end else if (wr_lim2) begin
         lim2_r <= wdata_in;
      end
   end

   // Clear bit stands for one cycle only, the pulse itself is timed elsewhere
   always @(posedge core_clk_in) begin
      if (rst_in) begin
         tclr_r <= 1'b0;
      end else if (wr_tclr) begin
         tclr_r <= wdata_in[`TCLR_BIT]; // RL13
      end else begin
         tclr_r <= 1'b0;
      end
   end

   always @* begin
      rd_sel = 8'h00;
      case (addr_in)
         `ADDR_CONFIG: begin
            rd_sel = cfg_r;
         end
         `ADDR_STATUS: begin
            rd_sel = status_r; // RL19
         end
         `ADDR_MASK: begin
            rd_sel = mask_r;
         end
         `ADDR_DIVISOR: begin
            rd_sel = div_r;
         end
         `ADDR_TAMPER_CLR: begin
            rd_sel = {tclr_r, 7'h00};
         end
         `ADDR_FIRST_TACH_INPUT_VALUE: begin
            rd_sel = cnt1; // RL4
         end
         `ADDR_SECOND_TACH_INPUT_VALUE: begin
            rd_sel = cnt2; // RL4
         end
         `ADDR_FIRST_TACH_INPUT_LIMIT: begin
            rd_sel = lim1_r;
         end
         `ADDR_SECOND_TACH_INPUT_LIMIT: begin
            rd_sel = lim2_r;
         end
         default: begin
            rd_sel = 8'h00;
         end
      endcase
   end

   // Read data stand for one cycle only; idle bus reads as zero
   always @(posedge core_clk_in) begin
      if (rst_in) begin
         rdata_out <= 8'h00;
      end else if (rd_in) begin
         rdata_out <= rd_sel;
      end else begin
         rdata_out <= 8'h00;
      end
   end

   // Open-drain alert: drive low when any unmasked status bit is set while enabled and not released
   assign unmasked       = status_r & ~mask_r; // RL16
   assign alert_allowed  = cfg_r[`CFG_ALERT_EN_BIT] & ~cfg_r[`CFG_RELEASE_BIT]; // RL18 RL20
   assign alert_n_out    = 1'b0;
   assign alert_n_oe_out = (|unmasked) & alert_allowed; // RL17
endmodule
`default_nettype wire

// [test/fan_alert_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
`include "fan_tach_consts.vh"
module fan_alert_monitor #(
   parameter TAMPER_PULSE_CYC = 50,
   parameter OSC_DIV_CYC      = 4
) (
   input wire logic       core_clk_in,
   input wire logic       rst_in,
   input wire logic [7:0] addr_in,
   input wire logic [7:0] wdata_in,
   input wire logic       wr_in,
   input wire logic       tamper_pin_out,
   input wire logic       tamper_pin_oe_out,
   input wire logic       alert_n_out,
   input wire logic       alert_n_oe_out
);
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (rst_in);
   wire logic cfg_wr = wr_in && addr_in == `ADDR_CONFIG;
   wire logic oe     = tamper_pin_oe_out;
   pin_level_a: assert property (tamper_pin_out == 1'b0)
      else $error("tamper pin driven high");
   alert_level_a: assert property (alert_n_out == 1'b0)
      else $error("alert driven high");
   cfg_pulse_a: assert property (cfg_wr && wdata_in[6] |-> ##[1:3] oe)
      else $error("no pulse after config clear");
   tclr_pulse_a: assert property
      (wr_in && addr_in == `ADDR_TAMPER_CLR && wdata_in[7] |-> ##[1:3] oe)
      else $error("no pulse after clear register");
   pulse_hold_a: assert property ($rose(oe) |-> oe [*8])
      else $error("pulse too short");
   release_off_a: assert property (cfg_wr && wdata_in[3] |=> !alert_n_oe_out)
      else $error("alert on while released");
   enable_off_a: assert property (cfg_wr && !wdata_in[1] |=> !alert_n_oe_out)
      else $error("alert on while disabled");
   mask_off_a: assert property
      (wr_in && addr_in == `ADDR_MASK && &wdata_in[2:0] |=> !alert_n_oe_out)
      else $error("masked status reached alert");
   cover property (alert_n_oe_out);
   cover property ($fell(oe));
   cover property (cfg_wr && wdata_in[0]);
endmodule
`default_nettype wire

// [test/fan_tach_partner.sv]
`timescale 1ns/1ps
`default_nettype none
module fan_tach_partner #(
   parameter HALF1 = 40,
   parameter HALF2 = 300
) (
   input  wire logic core_clk_in,
   input  wire logic intrude_in,
   input  wire logic pin_drv_in,
   input  wire logic pin_oe_in,
   output wire logic tach1_out,
   output wire logic tach2_out,
   output wire logic pin_out
);
   int   cnt1    = 0;
   int   cnt2    = 0;
   logic latch_r = 1'b0;
   always @(posedge core_clk_in) begin
      cnt1 <= (cnt1 + 1) % (2 * HALF1);
      cnt2 <= (cnt2 + 1) % (2 * HALF2);
   end
   assign tach1_out = cnt1 < HALF1;
   assign tach2_out = cnt2 < HALF2;
   // Battery-backed latch: only a low pin resets it
   always @(posedge core_clk_in) begin
      if (pin_oe_in && !pin_drv_in)
         latch_r <= 1'b0;
      else if (intrude_in)
         latch_r <= 1'b1;
   end
   assign pin_out = pin_oe_in ? pin_drv_in : latch_r;
endmodule
`default_nettype wire

// [test/test_fan_tach_tamper_alert_logic.sv]
`timescale 1ns/1ps
`default_nettype none
`include "fan_tach_consts.vh"
module test_fan_tach_tamper_alert_logic;
   logic        clk         = 1'b0;
   logic        rst         = 1'b1;
   logic [7:0]  addr        = 8'h00;
   logic [7:0]  wdata       = 8'h00;
   logic        wr          = 1'b0;
   logic        rd          = 1'b0;
   logic        intrude     = 1'b0;
   logic        rd_d        = 1'b0;
   logic [31:0] seed        = 32'hd912_ffaf;
   int          errors      = 0;
   int          comparisons = 0;
   int          lo_q[$];
   int          hi_q[$];
   int          e;
   wire  [7:0]  rdata;
   wire         t1, t2, pin, drv, oe, al_oe;
   fan_tach_tamper_alert_logic #(.TAMPER_PULSE_CYC(50), .OSC_DIV_CYC(4)) dut (
      .core_clk_in(clk), .rst_in(rst), .addr_in(addr), .wdata_in(wdata),
      .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .first_tach_input_in(t1),
      .second_tach_input_in(t2), .tamper_pin_in(pin), .tamper_pin_out(drv),
      .tamper_pin_oe_out(oe), .alert_n_out(), .alert_n_oe_out(al_oe));
   fan_tach_partner #(.HALF1(40), .HALF2(300)) far (.core_clk_in(clk), .intrude_in(intrude),
      .pin_drv_in(drv), .pin_oe_in(oe), .tach1_out(t1), .tach2_out(t2), .pin_out(pin));
   initial forever #2 clk = ~clk;
   task automatic fail(input string m);
      errors++;
      $display("Error %0t: %s", $time, m);
   endtask
   task automatic finish_test;
      if (errors == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // Read data only stand in the cycle after the strobe
   always @(posedge clk) rd_d <= rd;
   always @(negedge clk) begin
      if (rd_d) begin
         comparisons++;
         if (((rdata >= lo_q[0]) && (rdata <= hi_q[0])) !== 1'b1)
            fail("read mismatch");
         void'(lo_q.pop_front());
         void'(hi_q.pop_front());
      end
   end
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [7:0] a, input int lo, input int hi);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      lo_q.push_back(lo);
      hi_q.push_back(hi);
      @(posedge clk);
      rd <= 1'b0;
   endtask
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction
   task automatic wait_pulse;
      repeat (4) @(posedge clk);
      for (int i = 0; oe === 1'b1; i++) begin
         if (i > 200) begin
            fail("pulse never ends");
            finish_test();
         end
         @(posedge clk);
      end
   endtask
   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      rd_reg(`ADDR_CONFIG, 8, 8);
      rd_reg(`ADDR_DIVISOR, 80, 80);
      rd_reg(`ADDR_MASK, 0, 0);
      rd_reg(8'hff, 0, 0);
      seed = xs(seed);
      wr_reg(`ADDR_SECOND_TACH_INPUT_LIMIT, seed[7:0]);
      rd_reg(`ADDR_SECOND_TACH_INPUT_LIMIT, seed[7:0], seed[7:0]);
      intrude <= 1'b1;
      wr_reg(`ADDR_FIRST_TACH_INPUT_LIMIT, 8'h00);
      intrude <= 1'b0;
      wr_reg(`ADDR_SECOND_TACH_INPUT_LIMIT, 8'hff);
      rd_reg(`ADDR_STATUS, 4, 4);
      rd_reg(`ADDR_STATUS, 4, 4);
      wr_reg(`ADDR_TAMPER_CLR, 8'h80);
      wait_pulse();
      rd_reg(`ADDR_STATUS, 4, 4);
      rd_reg(`ADDR_STATUS, 0, 0);
      wr_reg(`ADDR_CONFIG, 8'h48);
      wait_pulse();
      rd_reg(`ADDR_CONFIG, 8, 8);
      wr_reg(`ADDR_CONFIG, 8'h03);
      for (int d = 0; d < 4; d++) begin
         wr_reg(`ADDR_DIVISOR, {d[1:0], d[1:0], 4'h0});
         repeat (3200) @(posedge clk);
         e = 160 >> (d + 2);
         rd_reg(`ADDR_FIRST_TACH_INPUT_VALUE, e - 1, e + 1);
         e = 1200 >> (d + 2);
         rd_reg(`ADDR_SECOND_TACH_INPUT_VALUE, e > 255 ? 255 : e - 1, e > 254 ? 255 : e + 1);
      end
      @(negedge clk);
      comparisons++;
      if (al_oe !== 1'b1)
         fail("alert missing");
      rd_reg(`ADDR_STATUS, 1, 1);
      wr_reg(`ADDR_MASK, 8'h07);
      wr_reg(`ADDR_MASK, 8'h00);
      repeat (400) @(posedge clk);
      wr_reg(`ADDR_CONFIG, 8'h0b);
      wr_reg(`ADDR_CONFIG, 8'h01);
      repeat (2) @(posedge clk);
      finish_test();
   end
endmodule
bind fan_tach_tamper_alert_logic fan_alert_monitor #(.TAMPER_PULSE_CYC(TAMPER_PULSE_CYC),
   .OSC_DIV_CYC(OSC_DIV_CYC)) mon (.*);
`default_nettype wire
